//--- common/sar_readout_pkg.sv
package sar_readout_pkg;

   localparam int          RESULT_W          = 18;
   localparam int          CONV_TIME_NS      = 1400;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          CONV_CYCLES       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FIFO_DEPTH        = 16;
   localparam int          CNT_W             = 8;
   localparam logic [17:0] RESULT_RESET      = 18'h00000;
   localparam logic [17:0] ALL_ONES          = 18'h3FFFF;
   localparam logic [17:0] MIDSCALE_CODE     = 18'h20000;
   localparam int          BIT_PAIR_HI       = 1;
   localparam int          MID_LO            = 2;
   localparam int          MID_HI            = 9;
   localparam int          PIN_LSB_PAIR16    = 2;
   localparam int          PIN_BYTE_LO       = 10;

   typedef enum logic [1:0] {
      ST_SAMPLE  = 2'b00,
      ST_CONVERT = 2'b01,
      ST_DONE    = 2'b11
   } conv_state_t;

endpackage : sar_readout_pkg

//--- verilog/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,      // System clock.
   input  wire logic             sys_rst,  // Synchronous reset.
   input  wire logic [WIDTH-1:0] in_data,  // Write data.
   input  wire logic             in_valid, // Write request.
   output logic                  in_ready, // Not full.
   output logic      [WIDTH-1:0] out_data, // Head word.
   output logic                  out_valid,// Not empty.
   input  wire logic             out_ready // Drain accept.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= AW'(wr_r + 1'b1);
         end
         if (pop) begin
            rd_r <= AW'(rd_r + 1'b1);
         end
         cnt_r <= (AW+1)'(cnt_r + push - pop);
      end
   end
endmodule : sample_fifo

//--- verilog/sar_adc_parallel_readout.sv
`timescale 1ns/1ps
module sar_adc_parallel_readout
   import sar_readout_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   input  wire logic                clk,             // System clock, 100 MHz.
   input  wire logic                sys_rst,         // Synchronous reset, high.
   input  wire logic                convert_start_n, // Start strobe, low active.
   input  wire logic                chip_select_n,   // Chip select, low active.
   input  wire logic                read_n,          // Read strobe, low active.
   input  wire logic                lsb_pair_select, // Picks the two lowest bits.
   input  wire logic                low_group_select,// Folds low bits to upper byte.
   input  wire logic [RESULT_W-1:0] sample_code,     // Code from the comparator array.
   output logic                     busy,            // Conversion running.
   output logic                     sampling,        // Input tracking.
   output logic     [RESULT_W-1:0] result_pin_o,    // Result pin drive level.
   output logic     [RESULT_W-1:0] result_pin_oe,   // Result pin drive enable.
   output logic     [RESULT_W-1:0] fifo_word,       // Oldest buffered result.
   output logic                     fifo_valid,      // Buffered result present.
   input  wire logic                fifo_ready,      // Consumer takes buffered result.
   output logic                     fifo_full        // Buffer cannot accept.
);

   ////////////////////////////////////////////////////////////////////////////
   conv_state_t         state_r;
   logic [CNT_W-1:0]    cnt_r;
   logic                start_n_d_r;
   logic                cs_n_d_r;
   logic [RESULT_W-1:0] held_r;
   logic [RESULT_W-1:0] latch_r;
   logic [RESULT_W-1:0] view;
   logic                start_fall;
   logic                cs_fall;
   logic                finish;
   logic                abort;
   logic                fifo_in_ready;
   logic [RESULT_W-1:0] fifo_head;
   logic                fifo_head_valid;

   assign start_fall = start_n_d_r && !convert_start_n;
   assign cs_fall    = cs_n_d_r && !chip_select_n;
   assign abort      = (state_r == ST_CONVERT) && ((start_fall && !chip_select_n) || cs_fall);
   // A full buffer stalls completion so no result is ever dropped on the way out.
   assign finish     = (state_r == ST_CONVERT) && (cnt_r == CNT_W'(CONV_CYC - 1)) && fifo_in_ready && !abort;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         start_n_d_r <= 1'b1;
         cs_n_d_r    <= 1'b1;
      end else begin
         start_n_d_r <= convert_start_n;
         cs_n_d_r    <= chip_select_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= ST_SAMPLE;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            ST_SAMPLE: begin
               if (start_fall && !chip_select_n) begin
                  state_r <= ST_CONVERT;
                  cnt_r   <= '0;
               end
            end
            ST_CONVERT: begin
               if (abort || finish) begin
                  state_r <= ST_DONE;
               end else if (cnt_r != CNT_W'(CONV_CYC - 1)) begin
                  cnt_r <= CNT_W'(cnt_r + 1'b1);
               end
            end
            ST_DONE: begin
               state_r <= ST_SAMPLE;
            end
            default: begin
               state_r <= ST_SAMPLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
      end else if (state_r == ST_SAMPLE && start_fall && !chip_select_n) begin
         busy <= 1'b1;
      end else if (abort || finish) begin
         busy <= 1'b0;
      end
   end

   // Tracking resumes one cycle after busy falls when selected, or on a later select fall.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sampling <= 1'b1;
      end else if (state_r == ST_SAMPLE && start_fall && !chip_select_n) begin
         sampling <= 1'b0;
      end else if (state_r == ST_DONE && !chip_select_n) begin
         sampling <= 1'b1;
      end else if (state_r == ST_SAMPLE && !busy && cs_fall) begin
         sampling <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         held_r <= RESULT_RESET;
      end else if (state_r == ST_SAMPLE && start_fall) begin
         held_r <= sample_code;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch_r <= RESULT_RESET;
      end else if (abort) begin
         latch_r <= RESULT_RESET;
      end else if (finish) begin
         latch_r <= held_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      view = ALL_ONES;
      case ({low_group_select, lsb_pair_select})
         2'b00: view = latch_r;
         2'b01: view[PIN_LSB_PAIR16 +: 2] = latch_r[BIT_PAIR_HI -: 2];
         2'b10: view[RESULT_W-1 -: 8] = latch_r[MID_HI -: 8];
         2'b11: view[PIN_BYTE_LO +: 2] = latch_r[BIT_PAIR_HI -: 2];
         default: view = ALL_ONES;
      endcase
   end

   // The view follows the selects every cycle, so a held-low read still tracks.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_pin_o  <= RESULT_RESET;
         result_pin_oe <= '0;
      end else begin
         result_pin_o  <= view;
         result_pin_oe <= {RESULT_W{!chip_select_n && !read_n}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sample_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_data   (held_r),
      .in_valid  (finish),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_head),
      .out_valid (fifo_head_valid),
      .out_ready (fifo_ready)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fifo_word  <= '0;
         fifo_valid <= 1'b0;
         fifo_full  <= 1'b0;
      end else begin
         fifo_word  <= fifo_head;
         fifo_valid <= fifo_head_valid;
         fifo_full  <= !fifo_in_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   busy_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_SAMPLE && start_fall && !chip_select_n) |=> busy)
      else $error("busy did not rise after start");
   no_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_SAMPLE && !busy && start_fall && chip_select_n) |=> !busy)
      else $error("start accepted without select");
   abort_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      abort |=> (!busy && latch_r == RESULT_RESET))
      else $error("abort did not clear result");
   drive_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      (chip_select_n || read_n) |=> (result_pin_oe == '0))
      else $error("pins driven while deselected");
   full_view_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!low_group_select && !lsb_pair_select) |=> (result_pin_o == $past(latch_r)))
      else $error("full word view wrong");
   pair_view_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!low_group_select && lsb_pair_select) |=> (result_pin_o[3:2] == $past(latch_r[1:0])))
      else $error("lsb pair view wrong");
   mid_view_a: assert property (@(posedge clk) disable iff (sys_rst)
      (low_group_select && !lsb_pair_select) |=> (result_pin_o[17:10] == $past(latch_r[9:2])
      && result_pin_o[9:0] == 10'h3FF))
      else $error("mid byte view wrong");
   byte_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
      (low_group_select && lsb_pair_select) |=> (result_pin_o[11:10] == $past(latch_r[1:0])))
      else $error("byte pair view wrong");
   latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!finish && !abort) |=> $stable(latch_r))
      else $error("result changed without completion");
   conv_len_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_CONVERT && !abort && cnt_r != CNT_W'(CONV_CYC - 1))
      |=> (busy && cnt_r == CNT_W'($past(cnt_r) + 1'b1)))
      else $error("conversion length wrong");

   ////////////////////////////////////////////////////////////////////////////
   // An accepted start is a single-cycle condition; the restart of tracking after an abort spans two cycles.
   // They are named once here so the properties below read as the steps they guard.
   sequence accept_s;
      state_r == ST_SAMPLE && start_fall && !chip_select_n;
   endsequence
   sequence abort_resume_s;
      abort ##1 (state_r == ST_DONE && !chip_select_n);
   endsequence

   count_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      accept_s |=> (state_r == ST_CONVERT && cnt_r == '0))
      else $error("conversion count did not start at zero");

   busy_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (busy && !abort && !finish) |=> busy)
      else $error("busy dropped during conversion");

   busy_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
      finish |=> !busy)
      else $error("busy stayed high after completion");

   idle_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_SAMPLE && !(start_fall && !chip_select_n)) |=> !busy)
      else $error("busy rose without an accepted start");

   latch_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      finish |=> (latch_r == $past(held_r)))
      else $error("result not latched at completion");

   // Tracking must never overlap a conversion, or the held code would be disturbed.
   hold_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
      accept_s |=> (!sampling && held_r == $past(sample_code)))
      else $error("input not held at start");

   track_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      busy |-> !sampling)
      else $error("tracking during conversion");

   done_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_DONE && !chip_select_n) |=> sampling)
      else $error("tracking not resumed at busy fall");

   cs_resume_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_SAMPLE && !busy && cs_fall && !start_fall) |=> sampling)
      else $error("tracking not resumed at select fall");

   abort_resume_a: assert property (@(posedge clk) disable iff (sys_rst)
      abort_resume_s |=> sampling)
      else $error("tracking not resumed after abort");

   cs_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == ST_CONVERT && cs_fall) |=> (!busy && state_r == ST_DONE))
      else $error("select fall did not abort");

   // The enable follows select and read one cycle later, so the bus is left undriven for the first cycle of a read.
   drive_on_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!chip_select_n && !read_n) |=> (result_pin_oe == {RESULT_W{1'b1}}))
      else $error("pins not driven while read");

   pair_ones_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!low_group_select && lsb_pair_select) |=> (result_pin_o[17:4] == 14'h3FFF && result_pin_o[1:0] == 2'h3))
      else $error("lsb pair view not padded with ones");

   byte_ones_a: assert property (@(posedge clk) disable iff (sys_rst)
      (low_group_select && lsb_pair_select) |=> (result_pin_o[17:12] == 6'h3F && result_pin_o[9:0] == 10'h3FF))
      else $error("byte pair view not padded with ones");
endmodule : sar_adc_parallel_readout

//--- verif/host_model.sv
`timescale 1ns/1ps
module host_model
   import sar_readout_pkg::*;
(
   input  wire logic                clk,              // System clock.
   input  wire logic [RESULT_W-1:0] result_pin_o,     // Pin level.
   input  wire logic [RESULT_W-1:0] result_pin_oe,    // Pin enable.
   output logic                     convert_start_n,  // Start strobe.
   output logic                     chip_select_n,    // Select.
   output logic                     read_n,           // Read strobe.
   output logic                     lsb_pair_select,  // Pair fold.
   output logic                     low_group_select, // Group fold.
   output logic     [RESULT_W-1:0] bus_level         // Resolved wire.
);
   logic [RESULT_W-1:0] last_r = '0;
   // A floating pin toggles each cycle, so stale data shows inverted after one undriven cycle and true again after two.
   always_ff @(posedge clk) last_r <= bus_level;
   assign bus_level = (result_pin_oe & result_pin_o) | (~result_pin_oe & ~last_r);
   initial begin
      convert_start_n = 1'b1;
      chip_select_n = 1'b1;
      read_n = 1'b1;
      lsb_pair_select = 1'b0;
      low_group_select = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic trim_reads();
      chip_select_n = 1'b0;
      repeat (3) begin
         read_n = 1'b0;
         step(2);
         read_n = 1'b1;
         step(2);
      end
   endtask : trim_reads
   task automatic start(input logic cs_n, input logic [1:0] sel, input logic rd_n);
      chip_select_n = cs_n;
      read_n = rd_n;
      {low_group_select, lsb_pair_select} = sel;
      step(13);
      convert_start_n = 1'b0;
      step(4);
      convert_start_n = 1'b1;
   endtask : start
   task automatic read_word(input logic lsb, input logic grp, output logic [RESULT_W-1:0] v);
      lsb_pair_select = lsb;
      low_group_select = grp;
      chip_select_n = 1'b0;
      read_n = 1'b0;
      step(2);
      v = bus_level;
   endtask : read_word
   task automatic abort(input int kind);
      if (kind == 0) begin
         convert_start_n = 1'b0;
         step(2);
         convert_start_n = 1'b1;
      end else begin
         chip_select_n = 1'b1;
         step(2);
         chip_select_n = 1'b0;
      end
      step(2);
   endtask : abort
endmodule : host_model

//--- verif/sar_adc_parallel_readout_test.sv
`timescale 1ns/1ps
module sar_adc_parallel_readout_test;
   import sar_readout_pkg::*;
   localparam int CV = 24;
   logic clk, sys_rst, cs_n, st_n, rd_n, lsb, grp, busy, sampling, fvalid, fready, ffull;
   logic [RESULT_W-1:0] code, pin_o, pin_oe, fword, bus, v;
   logic [RESULT_W-1:0] q[$];
   logic [RESULT_W-1:0] corners[4] = '{18'h00000, 18'h20000, 18'h1FFFF, 18'h3FFFF};
   int seed, n_fail, check_count, cycles, busy_cnt, busy_len;
   always #5 clk = ~clk;
   sar_adc_parallel_readout #(.CONV_CYC(CV)) i_sar_adc_parallel_readout (.clk(clk), .sys_rst(sys_rst),
      .convert_start_n(st_n), .chip_select_n(cs_n), .read_n(rd_n), .lsb_pair_select(lsb),
      .low_group_select(grp), .sample_code(code), .busy(busy), .sampling(sampling), .result_pin_o(pin_o),
      .result_pin_oe(pin_oe), .fifo_word(fword), .fifo_valid(fvalid), .fifo_ready(fready), .fifo_full(ffull));
   host_model i_host_model (.clk(clk), .result_pin_o(pin_o), .result_pin_oe(pin_oe), .convert_start_n(st_n),
      .chip_select_n(cs_n), .read_n(rd_n), .lsb_pair_select(lsb), .low_group_select(grp), .bus_level(bus));
   always @(posedge clk) begin
      cycles++;
      busy_cnt = busy ? busy_cnt + 1 : 0;
      if (busy) busy_len = busy_cnt;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   function automatic logic [RESULT_W-1:0] fold(input logic [RESULT_W-1:0] c, input logic l, input logic g);
      logic [RESULT_W-1:0] r;
      r = ALL_ONES;
      if (!l && !g) r = c;
      else if (l && !g) r[3:2] = c[1:0];
      else if (!l) r[17:10] = c[9:2];
      else r[11:10] = c[1:0];
      return r;
   endfunction : fold
   task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic convert(input logic [RESULT_W-1:0] c);
      code = c;
      i_host_model.start(1'b0, 2'($random(seed)), 1'($random(seed)));
      check(busy, 1'b1);
      check(sampling, 1'b0);
      for (int i = 0; i < 60 && busy; i++) i_host_model.step(1);
      i_host_model.step(1);
      check(busy, 1'b0);
      check(sampling, 1'b1);
      check(RESULT_W'(busy_len), RESULT_W'(CV));
      for (int m = 0; m < 4; m++) begin
         i_host_model.read_word(m[0], m[1], v);
         check(v, fold(c, m[0], m[1]));
         check(pin_oe, ALL_ONES);
         // Odd codes pulse the strobe between words, even codes hold it low throughout.
         if (c[0]) rd_n_release();
      end
      rd_n_release();
      check(pin_oe, RESULT_RESET);
   endtask : convert
   task automatic rd_n_release();
      i_host_model.read_n = 1'b1;
      i_host_model.step(2);
   endtask : rd_n_release
   initial begin
      seed = 91321;
      clk = 0;
      sys_rst = 1;
      code = '0;
      fready = 0;
      repeat (2) @(posedge clk);
      #1 sys_rst = 0;
      i_host_model.step(1);
      check(pin_oe, RESULT_RESET);
      check(busy, 1'b0);
      i_host_model.trim_reads();
      i_host_model.start(1'b1, 2'b00, 1'b1);
      i_host_model.step(3);
      check(busy, 1'b0);
      $display("test refused start done");
      for (int n = 0; n < FIFO_DEPTH; n++) begin
         convert(n < 4 ? corners[n] : RESULT_W'($random(seed)));
         q.push_back(code);
      end
      check(ffull, 1'b1);
      $display("test conversions and fold reads done");
      // Ready is offered at random; outputs trail a pop by a cycle, so the head is rechecked each pass.
      while (q.size() > 0) begin
         check(fvalid, 1'b1);
         check(fword, q[0]);
         fready = 1'($random(seed));
         i_host_model.step(1);
         if (fready) void'(q.pop_front());
         fready = 0;
         i_host_model.step(2);
      end
      check(fvalid, 1'b0);
      $display("test buffer drain done");
      for (int k = 0; k < 2; k++) begin
         code = RESULT_W'($random(seed));
         i_host_model.start(1'b0, 2'($random(seed)), 1'($random(seed)));
         i_host_model.step(3);
         i_host_model.abort(k);
         check(busy, 1'b0);
         i_host_model.read_word(1'b0, 1'b0, v);
         check(v, RESULT_RESET);
         rd_n_release();
      end
      $display("test abort done");
      stop_test();
   end
endmodule : sar_adc_parallel_readout_test
